// ===== caf_control_flags.sv
// Control and mode registers, sticky flags and interrupt request of the array.
`timescale 1ns/10ps
`default_nettype none
module caf_control_flags
  import caf_pkg::*;
#(
  parameter int NMOD = caf_pkg::NUM_MOD
) (
  input  wire logic                        sys_clk,          // 50 MHz clock
  input  wire logic                        rst,              // async reset
  input  wire logic [caf_pkg::ADDR_W-1:0]  sfr_addr,         // register address
  input  wire logic                        sfr_wr,           // byte write strobe
  input  wire logic [caf_pkg::DATA_W-1:0]  sfr_wdata,        // byte write data
  input  wire logic                        sfr_bit_wr,       // single-bit write
  input  wire logic [2:0]                  sfr_bit_sel,      // bit index
  input  wire logic                        sfr_bit_val,      // bit value
  input  wire logic                        sfr_rd,           // read strobe
  output logic      [caf_pkg::DATA_W-1:0]  sfr_rdata,        // read data
  input  wire logic                        counter_wrap,     // 0xffff->0 pulse
  input  wire logic [NMOD-1:0]             module_event,     // match/capture
  input  wire logic [NMOD-1:0]             module_irq_en,    // module irq en
  output logic                             counter_run_bit,  // counter runs
  output logic                             idle_suspend_bit, // idle suspend
  output logic                             watchdog_enable_bit, // wd enable
  output logic                             watchdog_lock_bit,   // wd lock
  output logic      [2:0]                  timebase_select,  // timebase
  output logic                             overflow_irq_enable, // ovf irq en
  output logic      [NMOD-1:0]             module_event_flag,   // flags
  output logic                             counter_overflow_flag, // ovf flag
  output logic                             array_irq         // shared request
);
  import caf_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // The control register only has room for three module flags.
  if (NMOD != NUM_MOD) begin : g_bad_nmod
    $error("caf_control_flags: NMOD must equal three");
  end

  ////////////////////////////////////////////////////////////////////////////
  // All state lives in one packed word, so reset and update each have a
  // single place and no flop can be missed by either of them.
  typedef struct packed {
    logic                cf;
    logic                cr;
    logic [NUM_MOD-1:0]  ccf;
    logic [DATA_W-1:0]   mode;
    logic [DATA_W-1:0]   rdata;
    logic                irq;
  } caf_state_t;

  caf_state_t q;
  caf_state_t next_q;

  // Byte writes replace the whole register, bit writes one bit of it, so a
  // core doing read-modify-write on a single bit touches nothing else.
  function automatic logic [7:0] caf_merge(input logic [7:0] old,
                                           input logic       byte_hit,
                                           input logic [7:0] wdata,
                                           input logic       bit_hit,
                                           input logic [2:0] sel,
                                           input logic       val);
    logic [7:0] res;
    res = old;
    if (byte_hit) begin
      res = wdata;
    end else if (bit_hit) begin
      res[sel] = val;
    end
    return res;
  endfunction

  function automatic logic [7:0] caf_ctrl_view(input caf_state_t s);
    logic [7:0] v;
    v = CTRL_RESET;
    v[CTRL_OVF] = s.cf;
    v[CTRL_RUN] = s.cr;
    v[NUM_MOD-1:0] = s.ccf;
    return v;
  endfunction

  logic ctrl_byte;
  logic ctrl_bit;
  logic mode_byte;
  logic mode_bit;
  assign ctrl_byte = sfr_wr && (sfr_addr == CTRL_ADDR);
  assign ctrl_bit  = sfr_bit_wr && (sfr_addr == CTRL_ADDR);
  assign mode_byte = sfr_wr && (sfr_addr == MODE_ADDR);
  assign mode_bit  = sfr_bit_wr && (sfr_addr == MODE_ADDR);

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [7:0] c;
    logic [7:0] m;
    // Both scratch bytes start at zero so that no path leaves them unset.
    c = 8'h00;
    m = 8'h00;
    next_q = q;
    c = caf_merge(caf_ctrl_view(q), ctrl_byte, sfr_wdata, ctrl_bit,
                  sfr_bit_sel, sfr_bit_val); // RQ9
    // Flags only clear by software writes; a hardware set is ORed last so
    // it beats a clear in the same cycle.
    next_q.cf  = c[CTRL_OVF] | counter_wrap;  // RQ1 RQ3 RQ11
    next_q.cr  = c[CTRL_RUN];                 // RQ4
    next_q.ccf = c[NUM_MOD-1:0] | module_event; // RQ6 RQ8 RQ11
    m = caf_merge(q.mode, mode_byte, sfr_wdata, mode_bit,
                  sfr_bit_sel, sfr_bit_val);
    m[MODE_UNUSED] = 1'b0;
    // Once locked, the watchdog enable cannot drop until the next reset.
    m[MODE_WDLK] = m[MODE_WDLK] | q.mode[MODE_WDLK];
    if (q.mode[MODE_WDLK]) begin
      m[MODE_WDEN] = m[MODE_WDEN] | q.mode[MODE_WDEN];
    end
    next_q.mode = m;
    // Read data is taken from the state before any same-cycle write, and it
    // stands until the next read so the core may sample it late.
    if (sfr_rd) begin
      if (sfr_addr == CTRL_ADDR) begin
        next_q.rdata = caf_ctrl_view(q); // RQ5
      end else if (sfr_addr == MODE_ADDR) begin
        next_q.rdata = q.mode;
      end else begin
        next_q.rdata = UNMAPPED_RD;
      end
    end
    // The request follows the flags by one cycle so it leaves a flip-flop.
    next_q.irq = (q.cf & q.mode[MODE_OVFIE])
               | (|(q.ccf & module_irq_en)); // RQ2 RQ7 RQ10
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      q <= '{cf: 1'b0, cr: 1'b0, ccf: '0, mode: MODE_RESET,
             rdata: 8'h00, irq: 1'b0};
    end else begin
      q <= next_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign sfr_rdata             = q.rdata;
  assign counter_run_bit       = q.cr;
  assign counter_overflow_flag = q.cf;
  assign module_event_flag     = q.ccf;
  assign idle_suspend_bit      = q.mode[MODE_IDLE];
  assign watchdog_enable_bit   = q.mode[MODE_WDEN];
  assign watchdog_lock_bit     = q.mode[MODE_WDLK];
  assign timebase_select       = q.mode[MODE_TB_HI:MODE_TB_LO];
  assign overflow_irq_enable   = q.mode[MODE_OVFIE];
  assign array_irq             = q.irq;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence ctrl_idle_s;
    !ctrl_byte && !ctrl_bit;
  endsequence

  sequence ovf_clear_s;
    ctrl_byte && !sfr_wdata[CTRL_OVF];
  endsequence

  ovf_set_a: assert property (counter_wrap |=> q.cf) // RQ1
    else $error("overflow flag not set after wrap");

  irq_ovf_a: assert property (q.cf && q.mode[MODE_OVFIE] |=> array_irq) // RQ2
    else $error("overflow flag did not raise request");

  ovf_hold_a: assert property (q.cf && !ctrl_byte && !ctrl_bit |=> q.cf) // RQ3
    else $error("overflow flag cleared by hardware");

  run_follow_a: assert property (ctrl_byte |=> // RQ4
      counter_run_bit == $past(sfr_wdata[CTRL_RUN]))
    else $error("run bit did not follow write");

  unused_zero_a: assert property (sfr_rd && sfr_addr == CTRL_ADDR |=> // RQ5
      sfr_rdata[CTRL_UNU_HI:CTRL_UNU_LO] == 3'b000)
    else $error("unused control bits read nonzero");

  mod_set_a: assert property (|module_event |=> // RQ6
      (q.ccf & $past(module_event)) == $past(module_event))
    else $error("module flag not set on event");

  irq_mod_a: assert property (|(q.ccf & module_irq_en) |=> array_irq) // RQ7
    else $error("module flag did not raise request");

  mod_hold_a: assert property (ctrl_idle_s |=> // RQ8
      (q.ccf & $past(q.ccf)) == $past(q.ccf))
    else $error("module flag cleared by hardware");

  bit_wr_a: assert property (ctrl_bit && sfr_bit_sel == 3'h6 |=> // RQ9
      counter_run_bit == $past(sfr_bit_val) && q.cf == $past(q.cf | counter_wrap))
    else $error("single bit write disturbed control register");

  mask_a: assert property (!q.mode[MODE_OVFIE] && !(|(q.ccf & module_irq_en)) // RQ10
      |=> !array_irq)
    else $error("masked overflow raised request");

  set_wins_a: assert property (ovf_clear_s and counter_wrap |=> q.cf) // RQ11
    else $error("clear beat a same-cycle set");

  ////////////////////////////////////////////////////////////////////////////
  // Software clears of the overflow flag, by byte and by single bit. A wrap
  // in the same cycle is left out here, since the set has to win then.
  sequence ovf_bit_clear_s;
    ctrl_bit && sfr_bit_sel == 3'h7 && !sfr_bit_val;
  endsequence

  sequence wrap_seen_s;
    counter_wrap && q.mode[MODE_OVFIE] && !mode_byte && !mode_bit;
  endsequence

  ovf_byte_clr_a: assert property ( // RQ3
      ovf_clear_s and !counter_wrap |=> !q.cf)
    else $error("byte write did not clear overflow flag");

  ovf_bit_clr_a: assert property ( // RQ3
      ovf_bit_clear_s and !counter_wrap |=> !q.cf)
    else $error("bit write did not clear overflow flag");

  // Two steps: the flag one edge after the wrap, the request one edge later.
  ovf_path_a: assert property ( // RQ2
      wrap_seen_s |=> q.cf ##1 array_irq)
    else $error("wrap did not reach the shared request");

  run_hold_a: assert property ( // RQ4
      ctrl_idle_s |=> counter_run_bit == $past(q.cr))
    else $error("run bit changed without a write");

  rd_ctrl_a: assert property ( // RQ5
      sfr_rd && sfr_addr == CTRL_ADDR |=>
      sfr_rdata == {$past(q.cf), $past(q.cr), 3'h0, $past(q.ccf)})
    else $error("control read did not return the flags");

  // A bit write aimed at the unused field must leave every stored bit as it
  // was, apart from hardware sets that arrive in the same cycle.
  unused_wr_a: assert property ( // RQ5
      ctrl_bit && !ctrl_byte && sfr_bit_sel inside {[3'h3:3'h5]} |=>
      caf_ctrl_view(q) == ($past(caf_ctrl_view(q))
                           | {$past(counter_wrap), 4'h0, $past(module_event)}))
    else $error("write to unused control bit changed the register");

  rd_mode_a: assert property ( // RQ10
      sfr_rd && sfr_addr == MODE_ADDR |=> sfr_rdata == $past(q.mode))
    else $error("mode read did not return the mode register");

  // Unmapped reads must not leak either register onto the bus.
  rd_unmapped_a: assert property (
      sfr_rd && sfr_addr != CTRL_ADDR && sfr_addr != MODE_ADDR
      |=> sfr_rdata == UNMAPPED_RD)
    else $error("unmapped read returned nonzero data");

  rd_hold_a: assert property (!sfr_rd |=> $stable(sfr_rdata))
    else $error("read data changed without a read");

  irq_quiet_a: assert property ( // RQ7
      !(q.cf && q.mode[MODE_OVFIE]) && !(|(q.ccf & module_irq_en))
      |=> !array_irq)
    else $error("request raised with no enabled flag");

  // Byte writes to the mode register land whole, apart from the unused bit,
  // while the lock is still open.
  mode_write_a: assert property ( // RQ10
      mode_byte && !q.mode[MODE_WDLK] |=>
      q.mode == {$past(sfr_wdata[7:5]), 1'b0, $past(sfr_wdata[3:0])})
    else $error("mode byte write did not land");

  mode_bit_a: assert property ( // RQ10
      mode_bit && !mode_byte && sfr_bit_sel == 3'h0 |=>
      overflow_irq_enable == $past(sfr_bit_val))
    else $error("bit write did not set the overflow interrupt enable");

  mode_unused_a: assert property (!q.mode[MODE_UNUSED])
    else $error("unused mode bit read as one");

  // The lock only ever rises, and while it stands the enable only rises.
  wd_lock_a: assert property (
      q.mode[MODE_WDLK] |=> q.mode[MODE_WDLK]
      && (q.mode[MODE_WDEN] || !$past(q.mode[MODE_WDEN])))
    else $error("watchdog lock or enable dropped while locked");

  ////////////////////////////////////////////////////////////////////////////
  // One set of checks per module flag, so a fault in one bit lane names
  // that lane instead of hiding in a vector compare.
  for (genvar i = 0; i < NUM_MOD; i++) begin : g_mod_chk
    mod_bit_set_a: assert property ( // RQ6
        module_event[i] |=> q.ccf[i])
      else $error("module flag not set by its event");

    mod_bit_clr_a: assert property ( // RQ8
        ctrl_bit && sfr_bit_sel == 3'(i) && !sfr_bit_val
        && !module_event[i] |=> !q.ccf[i])
      else $error("bit write did not clear module flag");

    mod_bit_irq_a: assert property ( // RQ7
        q.ccf[i] && module_irq_en[i] |=> array_irq)
      else $error("module flag did not raise request");

    // The clear and the event meet in one cycle; the event has to win.
    mod_bit_wins_a: assert property ( // RQ11
        ctrl_byte && !sfr_wdata[i] && module_event[i] |=> q.ccf[i])
      else $error("clear beat a same-cycle module event");
  end

endmodule
`default_nettype wire

// ===== caf_pkg.sv
// Register map, field positions and reset values of the counter array flags.
// How it works
// RQ1: The overflow flag is set by hardware when the 16-bit counter wraps from 0xFFFF to 0x0000.
// RQ2: A set overflow flag raises the shared array interrupt while the overflow interrupt is enabled.
// RQ3: Hardware never clears the overflow flag, not even on interrupt entry; software writes it to zero.
// RQ4: The run bit in bit 6 of the control register stops the counter at 0 and lets it count at 1.
// RQ5: Control bits 5 to 3 always read 000b and writes to them do nothing.
// RQ6: Module flags in bits 2, 1 and 0 are set by hardware on a match or capture of their module.
// RQ7: A set module flag raises the same shared interrupt when that module's interrupt is enabled.
// RQ8: Module flags persist until software clears them and are not cleared by servicing.
// RQ9: The control register sits at address 0xD8 and every bit can be written alone.
// RQ10: The mode register's overflow interrupt enable masks the overflow flag when it is 0.
// RQ11: A hardware set in the same cycle as a software clear wins and the flag stays set.
package caf_pkg;
  localparam int          ADDR_W      = 8;
  localparam int          DATA_W      = 8;
  localparam int          NUM_MOD     = 3;
  localparam logic [7:0]  CTRL_ADDR   = 8'hd8;
  localparam logic [7:0]  MODE_ADDR   = 8'hd9;
  // Control register field positions.
  localparam int          CTRL_OVF    = 7;
  localparam int          CTRL_RUN    = 6;
  localparam int          CTRL_UNU_HI = 5;
  localparam int          CTRL_UNU_LO = 3;
  localparam logic [7:0]  CTRL_RESET  = 8'h00;
  // Mode register field positions.
  localparam int          MODE_IDLE   = 7;
  localparam int          MODE_WDEN   = 6;
  localparam int          MODE_WDLK   = 5;
  localparam int          MODE_UNUSED = 4;
  localparam int          MODE_TB_HI  = 3;
  localparam int          MODE_TB_LO  = 1;
  localparam int          MODE_OVFIE  = 0;
  localparam logic [7:0]  MODE_RESET  = 8'h40;
  localparam logic [7:0]  UNMAPPED_RD = 8'h00;
endpackage

// ===== caf_core_model.sv
// Processor core model that issues register reads and writes.
`timescale 1ns/10ps
`default_nettype none
module caf_core_model (
  input  wire logic       sys_clk,     // clock
  output logic      [7:0] sfr_addr,    // address
  output logic            sfr_wr,      // byte write
  output logic      [7:0] sfr_wdata,   // write data
  output logic            sfr_bit_wr,  // bit write
  output logic      [2:0] sfr_bit_sel, // bit index
  output logic            sfr_bit_val, // bit value
  output logic            sfr_rd       // read strobe
);
  initial begin
    {sfr_addr, sfr_wdata, sfr_bit_sel, sfr_bit_val} = 20'h0;
    {sfr_wr, sfr_bit_wr, sfr_rd} = 3'h0;
  end
  //////////////////////////////////////////////////////////////
  // Flags are only ever cleared by these writes, never by the block.
  task automatic put(input logic [7:0] a, input logic [2:0] k,
                     input logic [7:0] d);
    @(posedge sys_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_bit_sel <= d[2:0];
    sfr_bit_val <= d[3];
    {sfr_wr, sfr_bit_wr, sfr_rd} <= k;
    @(posedge sys_clk);
    {sfr_wr, sfr_bit_wr, sfr_rd} <= 3'h0;
    // Address and write data flip so a stale value never looks like a request.
    sfr_addr <= ~a;
    sfr_wdata <= ~d;
  endtask
endmodule
`default_nettype wire

// ===== pca_control_status_flags_test.sv
// Self-checking bench for the counter array control and status flags.
`timescale 1ns/10ps
`default_nettype none
module pca_control_status_flags_test;
  import caf_pkg::*;
  logic sys_clk, rst, counter_wrap, sfr_wr, sfr_bit_wr, sfr_bit_val, sfr_rd;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
  logic [2:0] sfr_bit_sel, module_event, module_irq_en, module_event_flag;
  logic counter_run_bit, counter_overflow_flag, array_irq;
  logic idle_suspend_bit, watchdog_enable_bit, watchdog_lock_bit;
  logic overflow_irq_enable;
  logic [2:0] timebase_select;
  logic [7:0] st, md;
  int failures = 0;
  int compares = 0;
  assign st = {counter_overflow_flag, counter_run_bit, array_irq, 2'b00,
               module_event_flag};
  assign md = {idle_suspend_bit, watchdog_enable_bit, watchdog_lock_bit, 1'b0,
               timebase_select, overflow_irq_enable};
  caf_core_model caf_core_model_inst (.sys_clk(sys_clk),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
    .sfr_bit_wr(sfr_bit_wr), .sfr_bit_sel(sfr_bit_sel),
    .sfr_bit_val(sfr_bit_val), .sfr_rd(sfr_rd));
  caf_control_flags caf_control_flags_inst (.sys_clk(sys_clk), .rst(rst),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
    .sfr_bit_wr(sfr_bit_wr), .sfr_bit_sel(sfr_bit_sel),
    .sfr_bit_val(sfr_bit_val), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .counter_wrap(counter_wrap), .module_event(module_event),
    .module_irq_en(module_irq_en), .counter_run_bit(counter_run_bit),
    .idle_suspend_bit(idle_suspend_bit),
    .watchdog_enable_bit(watchdog_enable_bit),
    .watchdog_lock_bit(watchdog_lock_bit),
    .timebase_select(timebase_select),
    .overflow_irq_enable(overflow_irq_enable),
    .module_event_flag(module_event_flag),
    .counter_overflow_flag(counter_overflow_flag), .array_irq(array_irq));
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  //////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Kind k is {byte write, bit write, read}; a bit write packs val, sel in d.
  task automatic wr(input logic [2:0] k, input logic [7:0] a, d);
    caf_core_model_inst.put(a, k, d);
    @(posedge sys_clk);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    wr(3'h1, a, 8'h00);
    chk(sfr_rdata, exp);
  endtask
  // Pulses last one cycle; flags and request settle within two more edges.
  task automatic ev(input logic w, input logic [2:0] m);
    @(posedge sys_clk);
    counter_wrap <= w;
    module_event <= m;
    @(posedge sys_clk);
    counter_wrap <= 1'b0;
    module_event <= 3'h0;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  //////////////////////////////////////////////////////////////
  initial begin
    #200000;
    failures++;
    wrap_up();
  end
  initial begin
    rst = 1'b1;
    counter_wrap = 1'b0;
    module_event = 3'h0;
    module_irq_en = 3'h0;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    rd(CTRL_ADDR, 8'h00);
    rd(8'hd9, 8'h40);
    chk(md, 8'h40);
    rd(8'hd7, 8'h00);
    wr(3'h4, CTRL_ADDR, 8'h78);
    rd(CTRL_ADDR, 8'h40);
    wr(3'h2, CTRL_ADDR, 8'h06);
    chk(st, 8'h00);
    wr(3'h2, CTRL_ADDR, 8'h0d);
    rd(CTRL_ADDR, 8'h00);
    ev(1'b1, 3'h0);
    chk(st, 8'h80);
    wr(3'h4, 8'hd9, 8'h41);
    chk(st, 8'ha0);
    chk(md, 8'h41);
    rd(CTRL_ADDR, 8'h80);
    wr(3'h2, CTRL_ADDR, 8'h07);
    chk(st, 8'h00);
    fork
      wr(3'h2, CTRL_ADDR, 8'h07);
      ev(1'b1, 3'h0);
    join
    chk(st, 8'ha0);
    wr(3'h4, CTRL_ADDR, 8'h00);
    chk(st, 8'h00);
    for (int i = 0; i < 3; i++) begin
      ev(1'b0, 3'h1 << i);
      chk(st, 8'h01 << i);
      @(posedge sys_clk) module_irq_en <= 3'h1 << i;
      ev(1'b0, 3'h0);
      chk(st, 8'h20 | (8'h01 << i));
      wr(3'h2, CTRL_ADDR, 8'(i));
      chk(st, 8'h00);
    end
    // Lock the watchdog enable, then try to drop it with a byte write.
    wr(3'h4, 8'hd9, 8'hff);
    rd(8'hd9, 8'hef);
    wr(3'h4, 8'hd9, 8'h00);
    rd(8'hd9, 8'h60);
    chk(md, 8'h60);
    wrap_up();
  end
endmodule
`default_nettype wire
